// >>> logic/sgx_defines.vh
// Constants for the serial pin expander: chain geometry and shift timing.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef SGX_DEFINES_VH
`define SGX_DEFINES_VH
`define SGX_GROUP_BITS 8
`define SGX_MAX_GROUPS 8
`define SGX_CLK_PERIOD_NS 10
`define SGX_HALF_PERIOD_NS 80
`define SGX_HALF_CYCLES (`SGX_HALF_PERIOD_NS / `SGX_CLK_PERIOD_NS)
`define SGX_DEF_OUT_GROUPS 4
`define SGX_DEF_IN_GROUPS 4
`define SGX_DEF_FIFO_DEPTH 4
`define SGX_DEF_FIFO_AW 2
`endif

// >>> logic/sgx_fifo.v
// Small synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH equals two to the power AW; single clock, active-low reset.
`timescale 1ns/1ns
module sgx_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = 4,
   parameter AW = 2
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Fill side
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   // Drain side
   output wire [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   reg ready_reg;
   reg empty_reg;
   wire push;
   wire pop;
   wire [AW:0] count_next;

   // Ready is kept as a flop of its own so it leaves the block unbuffered
   assign in_ready = ready_reg;
   assign out_valid = ~empty_reg;
   assign out_data = mem[rd_ptr_reg];
   assign push = in_valid & ready_reg;
   assign pop = out_ready & ~empty_reg;
   assign count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

   always @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
         ready_reg <= 1'b1;
         empty_reg <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
         end
         count_reg <= count_next;
         ready_reg <= (count_next != DEPTH[AW:0]);
         empty_reg <= (count_next == {(AW+1){1'b0}});
      end
   end
endmodule

// >>> logic/sgx_expander.v
// Serial pin expander controller: drives a daisy chain of external 8-bit
// shift registers. Assumes start comes from logic on mclk; the serial input
// pin is asynchronous and is synchronised before use.
`timescale 1ns/1ns
`include "sgx_defines.vh"

module sgx_expander #(
   parameter OUT_GROUPS = `SGX_DEF_OUT_GROUPS,
   parameter IN_GROUPS = `SGX_DEF_IN_GROUPS,
   parameter FIFO_DEPTH = `SGX_DEF_FIFO_DEPTH,
   parameter FIFO_AW = `SGX_DEF_FIFO_AW
) (
   // Clock and reset
   input wire mclk,
   input wire resetn,
   // Software control
   input wire channel_command_start_bit,
   // Output level words
   input wire [OUT_GROUPS*`SGX_GROUP_BITS-1:0] channel_output_levels,
   input wire channel_output_levels_valid,
   output wire channel_output_levels_ready,
   // Input level words
   output reg [IN_GROUPS*`SGX_GROUP_BITS-1:0] channel_input_levels,
   output reg channel_input_levels_valid,
   // Expander chain pins
   output reg expander_serial_out,
   output reg expander_load_strobe,
   input wire expander_serial_in,
   output reg expander_chain_reset_n,
   output reg expander_shift_clk
);
   localparam OUT_BITS = OUT_GROUPS * `SGX_GROUP_BITS;
   localparam IN_BITS = IN_GROUPS * `SGX_GROUP_BITS;
   localparam TOT = (OUT_BITS > IN_BITS) ? OUT_BITS : IN_BITS;
   localparam [6:0] TOT_BITS = TOT[6:0];
   localparam integer HALF_CYC = `SGX_HALF_CYCLES - 1;
   localparam [7:0] HALF_LAST = HALF_CYC[7:0];
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_SHIFT = 2'h1;
   localparam [1:0] ST_LOAD = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Reset release and input synchroniser

   reg rst_meta_reg;
   reg rst_n;
   reg sin_meta_reg;
   reg sin_sync_reg;

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sin_meta_reg <= 1'b0;
         sin_sync_reg <= 1'b0;
      end else begin
         sin_meta_reg <= expander_serial_in;
         sin_sync_reg <= sin_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output word buffer

   wire [OUT_BITS-1:0] fifo_data;
   wire fifo_valid;
   wire frame_begin;
   wire [TOT-1:0] word_ext;

   sgx_fifo #(
      .WIDTH(OUT_BITS),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .clk(mclk),
      .rst_n(rst_n),
      .in_data(channel_output_levels),
      .in_valid(channel_output_levels_valid),
      .in_ready(channel_output_levels_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(frame_begin)
   );

   reg [OUT_BITS-1:0] cur_word_reg;
   wire [OUT_BITS-1:0] next_word;
   assign next_word = fifo_valid ? fifo_data : cur_word_reg;

   // Short output chains are padded at the front so data lands at the near end
   generate
      if (TOT > OUT_BITS) begin : g_pad
         assign word_ext = {{(TOT-OUT_BITS){1'b0}}, next_word};
      end else begin : g_nopad
         assign word_ext = next_word;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Frame engine

   reg [1:0] state_reg;
   reg [7:0] half_cnt_reg;
   reg [6:0] bit_cnt_reg;
   reg [TOT-1:0] out_sr_reg;
   reg [TOT-1:0] in_sr_reg;
   wire half_done;

   assign half_done = (half_cnt_reg == HALF_LAST);
   // A frame starts on leaving idle and at the end of each load pulse
   assign frame_begin = fifo_valid & (((state_reg == ST_IDLE) & channel_command_start_bit) |
                                      ((state_reg == ST_LOAD) & half_done));

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         half_cnt_reg <= 8'h00;
         bit_cnt_reg <= 7'h00;
         out_sr_reg <= {TOT{1'b0}};
         in_sr_reg <= {TOT{1'b0}};
         cur_word_reg <= {OUT_BITS{1'b0}};
         channel_input_levels <= {IN_BITS{1'b0}};
         channel_input_levels_valid <= 1'b0;
         expander_serial_out <= 1'b0;
         expander_load_strobe <= 1'b0;
         expander_chain_reset_n <= 1'b0;
         expander_shift_clk <= 1'b0;
      end else begin
         channel_input_levels_valid <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               half_cnt_reg <= 8'h00;
               if (channel_command_start_bit) begin
                  expander_chain_reset_n <= 1'b1;
                  cur_word_reg <= next_word;
                  out_sr_reg <= word_ext;
                  expander_serial_out <= word_ext[TOT-1];
                  bit_cnt_reg <= 7'h00;
                  state_reg <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               half_cnt_reg <= half_done ? 8'h00 : half_cnt_reg + 8'h01;
               if (half_done) begin
                  expander_shift_clk <= ~expander_shift_clk;
                  if (!expander_shift_clk) begin
                     // Rising edge: chain shifts, returned bit is captured
                     in_sr_reg <= {sin_sync_reg, in_sr_reg[TOT-1:1]};
                     bit_cnt_reg <= bit_cnt_reg + 7'h01;
                  end else if (bit_cnt_reg == TOT_BITS) begin
                     expander_load_strobe <= 1'b1;
                     state_reg <= ST_LOAD;
                  end else begin
                     out_sr_reg <= {out_sr_reg[TOT-2:0], 1'b0};
                     expander_serial_out <= out_sr_reg[TOT-2];
                  end
               end
            end
            ST_LOAD: begin
               half_cnt_reg <= half_done ? 8'h00 : half_cnt_reg + 8'h01;
               if (half_done) begin
                  expander_load_strobe <= 1'b0;
                  channel_input_levels <= in_sr_reg[IN_BITS-1:0];
                  channel_input_levels_valid <= 1'b1;
                  cur_word_reg <= next_word;
                  out_sr_reg <= word_ext;
                  expander_serial_out <= word_ext[TOT-1];
                  bit_cnt_reg <= 7'h00;
                  state_reg <= ST_SHIFT;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

// >>> test/sgx_expander_assertions.sv
// Checker for the serial pin expander: idle pin levels and frame timing.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
module sgx_expander_checker #(
   parameter OUT_GROUPS = 4,
   parameter IN_GROUPS = 4
) (
   // Clock and reset
   input logic mclk,
   input logic resetn,
   // Control and status
   input logic channel_command_start_bit,
   input logic channel_input_levels_valid,
   // Chain pins
   input logic expander_serial_out,
   input logic expander_load_strobe,
   input logic expander_chain_reset_n,
   input logic expander_shift_clk
);
   localparam int TOT = 8 * (OUT_GROUPS > IN_GROUPS ? OUT_GROUPS : IN_GROUPS);
   logic started_reg;
   int rise_cnt;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////
   // Remembers start and counts shift clocks within a frame
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         started_reg <= 1'h0;
         rise_cnt <= 0;
      end else begin
         started_reg <= started_reg | channel_command_start_bit;
         if (expander_load_strobe)
            rise_cnt <= 0;
         else if ($rose(expander_shift_clk))
            rise_cnt <= rise_cnt + 1;
      end
   end
   chain_held_a: assert property (!started_reg |-> !expander_chain_reset_n)
      else $error("chain reset left early");
   load_held_a: assert property (!started_reg |-> !expander_load_strobe)
      else $error("load strobe before start");
   clock_held_a: assert property (!started_reg |-> !expander_shift_clk)
      else $error("shift clock before start");
   clock_half_a: assert property ($rose(expander_shift_clk) |=>
      expander_shift_clk [*7] ##1 !expander_shift_clk) else $error("shift clock width");
   load_width_a: assert property ($rose(expander_load_strobe) |=>
      expander_load_strobe [*7] ##1 !expander_load_strobe) else $error("load width");
   data_steady_a: assert property (expander_shift_clk |-> $stable(expander_serial_out))
      else $error("serial out moved while clock high");
   frame_bits_a: assert property ($rose(expander_load_strobe) |-> rise_cnt == TOT)
      else $error("wrong bit count in frame");
   word_post_a: assert property ($fell(expander_load_strobe) |->
      channel_input_levels_valid ##1 !channel_input_levels_valid) else $error("input post");
   cover property ($rose(expander_chain_reset_n));
   cover property ($rose(expander_load_strobe));
   cover property (channel_input_levels_valid);
endmodule
bind sgx_expander sgx_expander_checker #(.OUT_GROUPS(OUT_GROUPS), .IN_GROUPS(IN_GROUPS))
   u_sgx_expander_checker (.mclk, .resetn, .channel_command_start_bit,
   .channel_input_levels_valid, .expander_serial_out, .expander_load_strobe,
   .expander_chain_reset_n, .expander_shift_clk);

// >>> test/sgx_chain_model.sv
// Behavioural daisy chain of serial-in and parallel-in shift registers.
// Assumes the shift clock idles low and the load strobe is active high.
`timescale 1ns/1ns
module sgx_chain_model #(
   parameter OUT_BITS = 32,
   parameter IN_BITS = 32
) (
   // Controller pins
   input logic expander_serial_out,
   input logic expander_load_strobe,
   input logic expander_chain_reset_n,
   input logic expander_shift_clk,
   output logic expander_serial_in,
   // Parallel pins
   input logic [IN_BITS-1:0] in_pins,
   output logic [OUT_BITS-1:0] out_pins
);
   logic [OUT_BITS-1:0] out_shift;
   logic [IN_BITS-1:0] in_shift;
   // Empty input stages refill with the inverse, never a stale copy
   always @(posedge expander_shift_clk or posedge expander_load_strobe
      or negedge expander_chain_reset_n) begin
      if (!expander_chain_reset_n) begin
         out_shift <= '0;
         in_shift <= '0;
         out_pins <= '0;
      end else if (expander_load_strobe) begin
         out_pins <= out_shift;
         in_shift <= in_pins;
      end else begin
         out_shift <= {out_shift[OUT_BITS-2:0], expander_serial_out};
         in_shift <= {~in_shift[0], in_shift[IN_BITS-1:1]};
      end
   end
   assign expander_serial_in = in_shift[0];
endmodule

// >>> test/tb_sgx_expander.sv
// Bench for the serial pin expander driving a behavioural chain model.
// Assumes four output and four input groups, so 32-bit frames.
`timescale 1ns/1ns
module tb_sgx_expander;
   logic mclk = 1'h0, resetn = 1'h0, channel_command_start_bit = 1'h0;
   logic channel_output_levels_valid = 1'h0, expander_serial_in;
   logic [31:0] channel_output_levels = 32'h0, in_pins = 32'h1E5A_C381, out_pins;
   logic [31:0] channel_input_levels;
   logic channel_output_levels_ready, channel_input_levels_valid, expander_serial_out;
   logic expander_load_strobe, expander_chain_reset_n, expander_shift_clk;
   logic [31:0] words [0:4] = '{32'h8000_0001, 32'h1234_5678, 32'hF0F0_0F0F,
      32'h0000_00FF, 32'h5555_AAAA};
   int n_mismatch = 0, checked = 0;
   always #5 mclk = ~mclk;
   sgx_expander u_sgx_expander (.mclk, .resetn, .channel_command_start_bit,
      .channel_output_levels, .channel_output_levels_valid, .channel_output_levels_ready,
      .channel_input_levels, .channel_input_levels_valid, .expander_serial_out,
      .expander_load_strobe, .expander_serial_in, .expander_chain_reset_n, .expander_shift_clk);
   sgx_chain_model u_sgx_chain_model (.expander_serial_out, .expander_load_strobe,
      .expander_chain_reset_n, .expander_shift_clk, .expander_serial_in, .in_pins, .out_pins);
   ////////////////////////////////////////////////////////////
   task end_of_test;
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task idle_check;
      repeat (200) @(posedge mclk);
      #1 cmp({expander_chain_reset_n, expander_load_strobe, expander_shift_clk}, 32'h0);
   endtask
   // Four words back to back, the fifth must be refused while full
   task fill_fifo;
      int i;
      for (i = 0; i < 5; i++) begin
         @(posedge mclk);
         channel_output_levels <= words[i];
         channel_output_levels_valid <= 1'h1;
         #1 cmp(channel_output_levels_ready, {31'h0, i < 4});
      end
      repeat (3) @(posedge mclk);
      channel_output_levels_valid <= 1'h0;
   endtask
   // Waits for the next input word post, bounded by 1000 clocks, a little under two 520-clock frames
   task wait_post;
      int t;
      t = 0;
      do begin
         @(posedge mclk);
         #1 t++;
      end while (channel_input_levels_valid !== 1'h1 && t < 1000);
      if (channel_input_levels_valid !== 1'h1) begin
         n_mismatch++;
         end_of_test;
      end
   endtask
   // Six frames: queued words in order, then the last one repeated
   task run_frames;
      int k;
      @(posedge mclk);
      channel_command_start_bit <= 1'h1;
      for (k = 0; k < 6; k++) begin
         wait_post;
         cmp(out_pins, words[k < 4 ? k : 3]);
         cmp(channel_input_levels, k == 0 ? 32'h0 : in_pins);
      end
      cmp(channel_output_levels_ready, 32'h1);
   endtask
   // Reset in mid-frame: pins fall back to idle, then one fresh frame after restart
   task reset_midrun;
      repeat (300) @(posedge mclk);
      channel_command_start_bit <= 1'h0;
      resetn <= 1'h0;
      repeat (4) @(posedge mclk);
      #1 cmp({expander_chain_reset_n, expander_load_strobe, expander_shift_clk}, 32'h0);
      @(posedge mclk);
      resetn <= 1'h1;
      idle_check;
      @(posedge mclk);
      channel_output_levels <= words[4];
      channel_output_levels_valid <= 1'h1;
      @(posedge mclk);
      channel_output_levels_valid <= 1'h0;
      @(posedge mclk);
      channel_command_start_bit <= 1'h1;
      wait_post;
      cmp(out_pins, words[4]);
      cmp(channel_input_levels, 32'h0);
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      resetn <= 1'h1;
      idle_check;
      fill_fifo;
      run_frames;
      reset_midrun;
      end_of_test;
   end
endmodule
